// *** pcrt_pkg.sv ***
package pcrt_pkg;
    // --------------------------------------------------------------
    // Geometry
    // --------------------------------------------------------------
    localparam int STAGES   = 3;
    localparam int BUF_DEPTH = 2;
    localparam int BUF_PTR_W = 1;
    // --------------------------------------------------------------
    // Reset values and counter constants
    // --------------------------------------------------------------
    localparam logic [STAGES-1:0] SHIFT_RST = 3'h0;
    localparam logic              COMP_RST  = 1'h0;
    localparam logic              AUX_RST   = 1'h0;
    localparam logic [1:0]        CNT_ZERO  = 2'h0;
    localparam logic [1:0]        CNT_ONE   = 2'h1;
    localparam logic [1:0]        CNT_FULL  = 2'h2;
    // --------------------------------------------------------------
    // Timing, informative
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_PS  = 4000;
    localparam int AUX_WIDTH_PS   = 1736000;
    localparam int AUX_PERIOD_PS  = 125000000;
    localparam int AUX_WIDTH_CYC  = AUX_WIDTH_PS / CLK_PERIOD_PS;
    localparam int AUX_PERIOD_CYC = AUX_PERIOD_PS / CLK_PERIOD_PS;
endpackage

// *** pcrt_buf.sv ***
`timescale 1ns/1ps
module pcrt_buf (
    // Clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    // Fill side
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic [pcrt_pkg::STAGES-1:0] in_data,
    // Drain side
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic [pcrt_pkg::STAGES-1:0]   out_data
);
    // --------------------------------------------------------------
    // Storage
    // --------------------------------------------------------------
    logic [pcrt_pkg::STAGES-1:0] mem_reg [pcrt_pkg::BUF_DEPTH];
    logic [pcrt_pkg::BUF_PTR_W-1:0] wr_reg;
    logic [pcrt_pkg::BUF_PTR_W-1:0] rd_reg;
    logic [1:0]                     cnt_reg;
    logic                           push;
    logic                           pop;

    assign in_ready  = (cnt_reg != pcrt_pkg::CNT_FULL);
    assign out_valid = (cnt_reg != pcrt_pkg::CNT_ZERO);
    assign out_data  = mem_reg[rd_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mem_reg[0] <= pcrt_pkg::SHIFT_RST;
            mem_reg[1] <= pcrt_pkg::SHIFT_RST;
        end else if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= pcrt_pkg::CNT_ZERO;
        end else begin
            if (push)
                wr_reg <= wr_reg + 1'b1;
            if (pop)
                rd_reg <= rd_reg + 1'b1;
            if (push && !pop)
                cnt_reg <= cnt_reg + pcrt_pkg::CNT_ONE;
            else if (pop && !push)
                cnt_reg <= cnt_reg - pcrt_pkg::CNT_ONE;
        end
    end
endmodule

// *** pcrt_retimer.sv ***
`timescale 1ns/1ps
module pcrt_retimer (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Compander control
    input  wire logic compander_reset,
    input  wire logic sixth_timing_phase,
    output logic      inverted_sixth_phase,
    output logic      amp_path_sel,
    output logic      atten_path_sel,
    // Coder decision bits
    input  wire logic bit_true_line,
    input  wire logic bit_false_line,
    // Retimer strobes
    input  wire logic in_shift,
    input  wire logic word_xfer,
    input  wire logic out_shift,
    // Retimed PCM
    output logic      pcm_true,
    output logic      pcm_comp,
    output logic      xfer_ready,
    // Frame-rate auxiliary
    input  wire logic address_pulse,
    input  wire logic sampling_clk_en,
    output logic      frame_rate_aux_pulse
);
    // --------------------------------------------------------------
    // Compander state
    // --------------------------------------------------------------
    logic comp_reg;

    // Sixth phase is inverted combinationally, not held to the clock edge
    assign inverted_sixth_phase = !sixth_timing_phase;

    // Reset wins over set: a late attenuate decision must not be lost
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            comp_reg <= pcrt_pkg::COMP_RST;
        else if (compander_reset)
            comp_reg <= 1'b0;
        else if (!inverted_sixth_phase)
            comp_reg <= comp_reg;
        else
            comp_reg <= 1'b1;
    end

    assign amp_path_sel   = comp_reg;
    assign atten_path_sel = !comp_reg;

    // --------------------------------------------------------------
    // Input register
    // --------------------------------------------------------------
    logic [pcrt_pkg::STAGES-1:0] in_reg;
    logic                        in_bit;
    logic                        buf_in_ready;
    logic                        buf_out_valid;
    logic                        load_out;
    logic [pcrt_pkg::STAGES-1:0] buf_data;

    // Coder supplies a complementary pair; the bit is set only when the true line is high and the false line low
    assign in_bit = bit_true_line && !bit_false_line;

    // Transfer and input shift never share a cycle, so no priority needed
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            in_reg <= pcrt_pkg::SHIFT_RST;
        else if (in_shift)
            in_reg <= {in_reg[pcrt_pkg::STAGES-2:0], in_bit};
    end

    // --------------------------------------------------------------
    // Transfer buffer
    // --------------------------------------------------------------
    // A transfer while the buffer is full is dropped; xfer_ready warns
    assign xfer_ready = buf_in_ready;

    pcrt_buf u_buf (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (word_xfer),
        .in_ready  (buf_in_ready),
        .in_data   (in_reg),
        .out_valid (buf_out_valid),
        .out_ready (load_out),
        .out_data  (buf_data)
    );

    // --------------------------------------------------------------
    // Output register
    // --------------------------------------------------------------
    logic [pcrt_pkg::STAGES-1:0] out_reg;
    logic [1:0]                  left_reg;

    // Load only when the previous half-word has fully left
    assign load_out = buf_out_valid && (left_reg == pcrt_pkg::CNT_ZERO) && !out_shift;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            out_reg  <= pcrt_pkg::SHIFT_RST;
            left_reg <= pcrt_pkg::CNT_ZERO;
        end else if (load_out) begin
            out_reg  <= buf_data;
            left_reg <= 2'(pcrt_pkg::STAGES);
        end else if (out_shift) begin
            out_reg  <= {out_reg[pcrt_pkg::STAGES-2:0], 1'b0};
            if (left_reg != pcrt_pkg::CNT_ZERO)
                left_reg <= left_reg - pcrt_pkg::CNT_ONE;
        end
    end

    assign pcm_true = out_reg[pcrt_pkg::STAGES-1];
    assign pcm_comp = !out_reg[pcrt_pkg::STAGES-1];

    // --------------------------------------------------------------
    // Frame-rate auxiliary pulse
    // --------------------------------------------------------------
    logic aux_reg;

    // Width and period follow the address pulse as sampled when sampling_clk_en is high
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            aux_reg <= pcrt_pkg::AUX_RST;
        else if (sampling_clk_en)
            aux_reg <= address_pulse;
    end

    assign frame_rate_aux_pulse = aux_reg;
endmodule

// *** pcrt_retimer_monitor.sv ***
`timescale 1ns/1ps
module pcrt_retimer_monitor (
    // Clock and reset
    input wire logic core_clk, rst,
    // Compander control
    input wire logic compander_reset, sixth_timing_phase, inverted_sixth_phase,
    input wire logic amp_path_sel, atten_path_sel,
    // Retimed PCM and aux
    input wire logic pcm_true, pcm_comp,
    input wire logic address_pulse, sampling_clk_en, frame_rate_aux_pulse
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    inv_phase_a: assert property (inverted_sixth_phase == !sixth_timing_phase)
        else $error("inverted phase not the inverse");
    path_compl_a: assert property (amp_path_sel != atten_path_sel)
        else $error("path selects not complementary");
    comp_clear_a: assert property (compander_reset |=> !amp_path_sel)
        else $error("compander reset did not clear");
    comp_set_a: assert property (!compander_reset && inverted_sixth_phase |=> amp_path_sel)
        else $error("inverted phase did not set");
    comp_hold_a: assert property (!compander_reset && !inverted_sixth_phase
        |=> $stable(amp_path_sel)) else $error("compander flop moved unasked");
    pcm_pair_a: assert property (pcm_comp == !pcm_true)
        else $error("pcm pair not complementary");
    aux_take_a: assert property (sampling_clk_en
        |=> frame_rate_aux_pulse == $past(address_pulse))
        else $error("aux did not take address pulse");
    aux_hold_a: assert property (!sampling_clk_en |=> $stable(frame_rate_aux_pulse))
        else $error("aux moved without sampling clock");
endmodule
bind pcrt_retimer pcrt_retimer_monitor i_mon (.core_clk, .rst, .compander_reset,
    .sixth_timing_phase, .inverted_sixth_phase, .amp_path_sel, .atten_path_sel,
    .pcm_true, .pcm_comp, .address_pulse, .sampling_clk_en, .frame_rate_aux_pulse);

// *** pcrt_coder_model.sv ***
`timescale 1ns/1ps
module pcrt_coder_model (
    // Clock
    input wire logic core_clk,
    // Decision bits and strobes
    output logic     bit_true_line = 1'h0, bit_false_line = 1'h1,
    output logic     in_shift = 1'h0, word_xfer = 1'h0, out_shift = 1'h0
);
    // Three bits msb first, then one transfer; never both strobes at once
    task put_half(input logic [2:0] b);
        for (int i = 2; i >= 0; i--) begin
            @(posedge core_clk);
            bit_true_line <= b[i];
            bit_false_line <= ~b[i];
            in_shift <= 1'h1;
            @(posedge core_clk);
            in_shift <= 1'h0;
            bit_true_line <= ~b[i];
            bit_false_line <= b[i];
        end
        @(posedge core_clk);
        word_xfer <= 1'h1;
        @(posedge core_clk);
        word_xfer <= 1'h0;
    endtask
    // Output strobe at half the input bit rate
    task pulse_out;
        @(posedge core_clk);
        out_shift <= 1'h1;
        @(posedge core_clk);
        out_shift <= 1'h0;
        repeat (2) @(posedge core_clk);
    endtask
endmodule

// *** pcm_coder_timing_retimer_test.sv ***
`timescale 1ns/1ps
module pcm_coder_timing_retimer_test;
    logic core_clk = 1'h0, rst = 1'h1, compander_reset = 1'h0, sixth_timing_phase = 1'h1;
    logic address_pulse = 1'h0, sampling_clk_en = 1'h0;
    logic bit_true_line, bit_false_line, in_shift, word_xfer, out_shift;
    logic inverted_sixth_phase, amp_path_sel, atten_path_sel;
    logic pcm_true, pcm_comp, xfer_ready, frame_rate_aux_pulse;
    int   fail_count = 0, compares = 0;
    initial forever #2 core_clk = ~core_clk;
    pcrt_coder_model i_coder (.core_clk, .bit_true_line, .bit_false_line, .in_shift,
        .word_xfer, .out_shift);
    pcrt_retimer i_dut (.core_clk, .rst, .compander_reset, .sixth_timing_phase,
        .inverted_sixth_phase, .amp_path_sel, .atten_path_sel, .bit_true_line,
        .bit_false_line, .in_shift, .word_xfer, .out_shift, .pcm_true, .pcm_comp,
        .xfer_ready, .address_pulse, .sampling_clk_en, .frame_rate_aux_pulse);
    task check(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            $display("unexpected at %0t: %s", $time, what);
            fail_count++;
        end
    endtask
    task print_verdict;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task test_compander;
        @(posedge core_clk) sixth_timing_phase <= 1'h0;
        @(negedge core_clk) check(inverted_sixth_phase, 1'h1, "inverted phase");
        @(posedge core_clk) sixth_timing_phase <= 1'h1;
        @(negedge core_clk) check(amp_path_sel, 1'h1, "amp path");
        check(atten_path_sel, 1'h0, "atten path");
        // Reset and set together: reset must win
        @(posedge core_clk) {compander_reset, sixth_timing_phase} <= 2'h2;
        @(posedge core_clk) {compander_reset, sixth_timing_phase} <= 2'h1;
        @(negedge core_clk) check(amp_path_sel, 1'h0, "reset priority");
        check(atten_path_sel, 1'h1, "atten after reset");
        $display("test_compander done");
    endtask
    task test_aux;
        @(posedge core_clk) {address_pulse, sampling_clk_en} <= 2'h3;
        @(posedge core_clk) {address_pulse, sampling_clk_en} <= 2'h0;
        @(negedge core_clk) check(frame_rate_aux_pulse, 1'h1, "aux held");
        @(posedge core_clk) sampling_clk_en <= 1'h1;
        @(posedge core_clk) sampling_clk_en <= 1'h0;
        @(negedge core_clk) check(frame_rate_aux_pulse, 1'h0, "aux cleared");
        $display("test_aux done");
    endtask
    // Three halves with no output shifts: buffer fills, then drain in order
    task test_word;
        logic [8:0] q;
        q = {3'h5, 3'h3, 3'h6};
        i_coder.put_half(3'h5);
        i_coder.put_half(3'h3);
        i_coder.put_half(3'h6);
        @(negedge core_clk) check(xfer_ready, 1'h0, "buffer not full");
        for (int k = 8; k >= 0; k--) begin
            check(pcm_true, q[k], "pcm true bit");
            check(pcm_comp, ~q[k], "pcm comp bit");
            i_coder.pulse_out();
            @(negedge core_clk);
        end
        check(xfer_ready, 1'h1, "buffer not drained");
        $display("test_word done");
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'h0;
        test_compander;
        test_aux;
        test_word;
        print_verdict;
    end
    initial begin
        #20000;
        fail_count++;
        print_verdict;
    end
endmodule
